// ### tvc_defs.vh
`ifndef TVC_DEFS_VH
`define TVC_DEFS_VH

// Fixed-point shifts
`define TVC_CORR_SHIFT 14
`define TVC_SCALE_SHIFT 16
// Unity gains
`define TVC_UNITY_SCALE_GAIN 32'h00010000
`define TVC_UNITY_CORR_GAIN 16'h4000
// Vendor coefficients, fixed at build
`define TVC_VENDOR_TC_OFFSET 16'h0000
`define TVC_VENDOR_TC_GAIN 16'h4000
`define TVC_VENDOR_REF_OFFSET 16'h0000
`define TVC_VENDOR_REF_GAIN 16'h4000
// Reference junction selection codes
`define TVC_REF_INTERNAL 2'h0
`define TVC_REF_EXTERNAL 2'h2
// Output clamp
`define TVC_OUT_MAX 16'h7fff
`define TVC_OUT_MIN 16'h8000

`endif

// ### tvc_channel.v
// Contract
// - Each limit compared only when enabled
// - Passing a limit sets its status flag
// - Limits are signed tenths of degree
// - Vendor enable applies stored vendor coefficients
// - Vendor coefficients are fixed, not writable
// - User enable applies user offset, gain
// - Scaling enable applies scaling offset, gain
// - Scaling offset adds one output step
// - Scaling gain 65536 means unity
// - Store raw samples, rerun chain each
// - Vendor: subtract offset, multiply, shift 14
// - User: subtract offset, multiply, shift 14
// - Scale: multiply, shift 16, add offset
// - Internal mode uses own junction sensor
// - External mode uses supplied junction temperature
// - Clamp output to signed 16 bits
`timescale 1ns/1ps
`include "tvc_defs.vh"

module tvc_channel
(
	// Clock and reset
	input wire i_ref_clk,
	input wire i_reset_n,
	// Converter samples
	input wire i_sample_valid,
	input wire signed [15:0] i_tc_sample,
	input wire signed [15:0] i_junction_sample,
	// Configuration
	input wire i_vendor_enable,
	input wire i_user_enable,
	input wire i_scale_enable,
	input wire i_limit1_enable,
	input wire i_limit2_enable,
	input wire [1:0] i_ref_select,
	input wire signed [15:0] i_user_offset,
	input wire signed [15:0] i_user_gain,
	input wire signed [31:0] i_scale_offset,
	input wire [31:0] i_scale_gain,
	input wire signed [15:0] i_limit1_value,
	input wire signed [15:0] i_limit2_value,
	// Process data from master
	input wire signed [15:0] i_reference_junction_input,
	// Results
	output reg signed [15:0] o_tc_raw,
	output reg signed [15:0] o_junction_raw,
	output reg signed [15:0] o_value,
	output reg o_value_valid,
	output reg o_limit1_flag,
	output reg o_limit2_flag
);

	// Signed 48-bit saturate to 16 bits
	function [15:0] sat16;
		input signed [47:0] v;
		begin
			if (v > $signed({32'h00000000, `TVC_OUT_MAX}))
				sat16 = `TVC_OUT_MAX;
			else if (v < $signed({32'hffffffff, `TVC_OUT_MIN}))
				sat16 = `TVC_OUT_MIN;
			else
				sat16 = v[15:0];
		end
	endfunction

	// Offset-gain correction stage, shift 14
	function signed [47:0] corr;
		input signed [47:0] x;
		input signed [15:0] off;
		input signed [15:0] gain;
		reg signed [47:0] d;
		reg signed [47:0] p;
		begin
			d = x - {{32{off[15]}}, off};
			p = d * {{32{gain[15]}}, gain};
			corr = p >>> `TVC_CORR_SHIFT;
		end
	endfunction

	localparam ST_IDLE = 2'h0;
	localparam ST_CORR = 2'h1;
	localparam ST_SCALE = 2'h2;
	localparam ST_LIMIT = 2'h3;

	reg [1:0] state_reg;
	reg signed [47:0] acc_reg;
	reg signed [47:0] acc_next;
	reg signed [15:0] junc_reg;
	reg signed [15:0] value_next;
	reg signed [47:0] vend;
	reg signed [47:0] junc_wide;
	reg signed [47:0] scaled;

	// Vendor stage for thermocouple and junction samples
	always @*
	begin
		vend = {{32{i_tc_sample[15]}}, i_tc_sample};
		junc_wide = {{32{i_junction_sample[15]}}, i_junction_sample};
		if (i_vendor_enable)
		begin
			vend = corr(vend, `TVC_VENDOR_TC_OFFSET, `TVC_VENDOR_TC_GAIN);
			junc_wide = corr(junc_wide, `TVC_VENDOR_REF_OFFSET, `TVC_VENDOR_REF_GAIN);
		end
	end

	// Scaling stage and user correction stage
	always @*
	begin
		scaled = acc_reg;
		if (i_scale_enable)
			scaled = ((acc_reg * $signed({16'h0000, i_scale_gain})) >>> `TVC_SCALE_SHIFT)
				+ $signed({{16{i_scale_offset[31]}}, i_scale_offset});
		value_next = sat16(scaled);
		acc_next = acc_reg;
		if (state_reg == ST_CORR && i_user_enable)
			acc_next = corr(acc_reg, i_user_offset, i_user_gain);
	end

	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_IDLE;
			acc_reg <= 48'h000000000000;
			junc_reg <= 16'h0000;
			o_tc_raw <= 16'h0000;
			o_junction_raw <= 16'h0000;
			o_value <= 16'h0000;
			o_value_valid <= 1'b0;
			o_limit1_flag <= 1'b0;
			o_limit2_flag <= 1'b0;
		end
		else
		begin
			o_value_valid <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (i_sample_valid)
					begin
						o_tc_raw <= i_tc_sample;
						o_junction_raw <= i_junction_sample;
						acc_reg <= vend;
						if (i_ref_select == `TVC_REF_EXTERNAL)
							junc_reg <= i_reference_junction_input;
						else
							junc_reg <= sat16(junc_wide);
						state_reg <= ST_CORR;
					end
				end
				ST_CORR:
				begin
					acc_reg <= acc_next;
					state_reg <= ST_SCALE;
				end
				ST_SCALE:
				begin
					// Junction temperature added to measured difference
					o_value <= sat16({{32{value_next[15]}}, value_next} + {{32{junc_reg[15]}}, junc_reg});
					state_reg <= ST_LIMIT;
				end
				ST_LIMIT:
				begin
					o_limit1_flag <= i_limit1_enable && (o_value > i_limit1_value);
					o_limit2_flag <= i_limit2_enable && (o_value > i_limit2_value);
					o_value_valid <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

// ### tvc_chk_assertions.sv
`timescale 1ns/1ps
module tvc_chk
(
	// Inputs
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire i_sample_valid,
	input wire signed [15:0] i_tc_sample,
	input wire i_limit1_enable,
	input wire signed [15:0] i_limit1_value,
	// Outputs
	input wire signed [15:0] o_tc_raw,
	input wire signed [15:0] o_value,
	input wire o_value_valid,
	input wire o_limit1_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_result;
		i_sample_valid ##4 o_value_valid;
	endsequence
	chk_result_in_four: assert property (i_sample_valid |-> s_result) else $error("no result");
	chk_raw_stored: assert property (i_sample_valid |=> o_tc_raw == $past(i_tc_sample)) else $error("raw");
	chk_raw_only_new: assert property ($changed(o_tc_raw) |-> $past(i_sample_valid)) else $error("raw moved");
	chk_valid_once: assert property (o_value_valid |=> !o_value_valid) else $error("valid long");
	chk_value_then_valid: assert property ($changed(o_value) |=> o_value_valid) else $error("no valid");
	chk_limit_off: assert property (o_value_valid && !i_limit1_enable |-> !o_limit1_flag) else $error("flag");
	chk_limit_cmp: assert property (o_value_valid && i_limit1_enable |->
		o_limit1_flag == (o_value > i_limit1_value)) else $error("compare");
	chk_flag_moves: assert property ($changed(o_limit1_flag) |-> o_value_valid) else $error("flag moved");
endmodule
bind tvc_channel tvc_chk tvc_chk_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sample_valid(i_sample_valid),
	.i_tc_sample(i_tc_sample), .i_limit1_enable(i_limit1_enable), .i_limit1_value(i_limit1_value),
	.o_tc_raw(o_tc_raw), .o_value(o_value), .o_value_valid(o_value_valid), .o_limit1_flag(o_limit1_flag));

// ### tvc_master.sv
`timescale 1ns/1ps
module tvc_master
(
	// Request
	input wire i_ext,
	input wire [15:0] i_temp,
	// Process data
	output wire [1:0] o_ref_select,
	output wire [15:0] o_ref_temp
);
	assign o_ref_select = i_ext ? 2'h2 : 2'h0;
	assign o_ref_temp = i_temp;
	// No producer codeword port; host owns gain math
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg i_reset_n = 1'b0;
	reg sv = 1'b0;
	reg ve = 1'b0, ue = 1'b0, se = 1'b0, e1 = 1'b0, e2 = 1'b0, ext = 1'b0;
	reg signed [15:0] ts = 16'h0, js = 16'h0, uo = 16'h0, ug = 16'h0, l1v = 16'h0, l2v = 16'h0, tmp = 16'h0;
	reg signed [31:0] so = 32'h0;
	reg [31:0] sg = 32'h0;
	reg [17:0] q[$];
	reg [17:0] e;
	wire [1:0] sel;
	wire [15:0] rj;
	wire signed [15:0] val;
	wire [15:0] tr, jr;
	wire vv, f1, f2;
	integer num_errors = 0, checked = 0, n, cyc = 0;
	always #2.5 clk = ~clk;
	tvc_master tvc_master_i (.i_ext(ext), .i_temp(tmp), .o_ref_select(sel), .o_ref_temp(rj));
	tvc_channel tvc_channel_i (.i_ref_clk(clk), .i_reset_n(i_reset_n), .i_sample_valid(sv), .i_tc_sample(ts),
		.i_junction_sample(js), .i_vendor_enable(ve), .i_user_enable(ue), .i_scale_enable(se),
		.i_limit1_enable(e1), .i_limit2_enable(e2), .i_ref_select(sel), .i_user_offset(uo), .i_user_gain(ug),
		.i_scale_offset(so), .i_scale_gain(sg), .i_limit1_value(l1v), .i_limit2_value(l2v),
		.i_reference_junction_input(rj), .o_tc_raw(tr), .o_junction_raw(jr), .o_value(val),
		.o_value_valid(vv), .o_limit1_flag(f1), .o_limit2_flag(f2));
	function automatic longint sat(input longint x);
		sat = x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
	endfunction
	function automatic [17:0] expv();
		longint t;
		t = ts;
		if (ue) t = ((t - uo) * ug) >>> 14;
		if (se) t = ((t * $signed({1'b0, sg})) >>> 16) + so;
		t = sat(sat(t) + (ext ? tmp : js));
		expv = {t[15:0], e1 && t > l1v, e2 && t > l2v};
	endfunction
	task end_of_test;
		$display("errors=%0d checked=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task go;
		@(posedge clk) #1;
		ts = $urandom_range(16000) - 8000;
		js = $urandom_range(1000) - 500;
		tmp = $urandom_range(1000) - 500;
		uo = $urandom_range(2000) - 1000;
		ug = $urandom_range(16'h5000, 16'h3000);
		so = $urandom_range(4000) - 2000;
		sg = $urandom_range(32'h40000);
		l1v = $urandom_range(6000) - 3000;
		l2v = $urandom_range(6000) - 3000;
		{ve, ue, se, e1, e2, ext} = $urandom;
		sv = 1'b1;
		q.push_back(expv());
		@(posedge clk) #1 sv = 1'b0;
		repeat (4) @(posedge clk);
	endtask
	always @(negedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			num_errors = num_errors + 1;
			end_of_test;
		end
		if (vv)
		begin
			checked = checked + 1;
			e = q.pop_front();
			if (e !== {val, f1, f2})
			begin
				num_errors = num_errors + 1;
				$display("Error t=%0t exp=%h got=%h", $time, e, {val, f1, f2});
			end
			checked = checked + 1;
			if ({tr, jr} !== {ts, js})
			begin
				num_errors = num_errors + 1;
				$display("Error t=%0t exp=%h got=%h", $time, {ts, js}, {tr, jr});
			end
		end
	end
	initial
	begin
		void'($urandom(82));
		repeat (8) @(posedge clk);
		#1 i_reset_n = 1'b1;
		for (n = 0; n < 300; n = n + 1)
			go;
		repeat (8) @(posedge clk);
		end_of_test;
	end
endmodule
